// File: core/ccc_pkg.sv
// ==========================================================
// constants of the charge cycle controller
package ccc_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned INT_PULSE_NS = 256_000;
	localparam int unsigned INT_PULSE_CYC =
		(INT_PULSE_NS / 1000) * (CLK_HZ / 1_000_000);
	localparam int unsigned BLINK_HZ = 1;
	localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
	localparam int unsigned TIMER_TICK_CYC = CLK_HZ;
	localparam int unsigned HOUR_SEC = 3600;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_INPUT_LIMIT = 8'h00;
	localparam logic [7:0] OFS_CHARGE_CONFIG = 8'h04;
	localparam logic [7:0] OFS_FAST_CURRENT = 8'h08;
	localparam logic [7:0] OFS_PRECHARGE_CURRENT = 8'h0C;
	localparam logic [7:0] OFS_VOLTAGE_CONFIG = 8'h10;
	localparam logic [7:0] OFS_TIMER_TERM = 8'h14;
	localparam logic [7:0] OFS_COMPENSATION = 8'h18;
	localparam logic [7:0] OFS_MISC_CONTROL = 8'h1C;
	localparam logic [7:0] OFS_SYSTEM_STATUS = 8'h20;
	localparam logic [7:0] OFS_FAULT_STATUS = 8'h24;
	localparam logic [3:0] NUM_RW_REGS = 4'h8;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_INPUT_LIMIT = 8'h00;
	localparam logic [7:0] RST_CHARGE_CONFIG = 8'h10;
	localparam logic [7:0] RST_FAST_CURRENT = 8'h60;
	localparam logic [7:0] RST_PRECHARGE_CURRENT = 8'h11;
	localparam logic [7:0] RST_VOLTAGE_CONFIG = 8'hB2;
	localparam logic [7:0] RST_TIMER_TERM = 8'h8A;
	localparam logic [7:0] RST_COMPENSATION = 8'h00;
	localparam logic [7:0] RST_MISC_CONTROL = 8'h40;

	// ==========================================================
	// field positions and codes
	localparam int unsigned CFG_CHG_LSB = 4;
	localparam logic [1:0] CFG_CHG_ENABLE = 2'h1;
	localparam int unsigned TT_TERM_EN_BIT = 7;
	localparam int unsigned TT_TIMER_EN_BIT = 3;
	localparam int unsigned TT_TIMER_LSB = 1;
	localparam int unsigned TT_COOL20_BIT = 0;
	localparam int unsigned MISC_HALF_EN_BIT = 6;
	localparam int unsigned MISC_FORCE_OFF_BIT = 5;
	localparam int unsigned MISC_WARM_LOW_BIT = 4;
	localparam int unsigned VC_RECHARGE_BIT = 0;
	localparam logic [1:0] PH_DISABLED = 2'h0;
	localparam logic [1:0] PH_PRECHARGE = 2'h1;
	localparam logic [1:0] PH_FAST = 2'h2;
	localparam logic [1:0] PH_DONE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// current and voltage scaling, mA and mV
	localparam logic [12:0] PRECOND_MA = 13'h0064;
	localparam logic [12:0] PRE_BASE_MA = 13'h0080;
	localparam logic [12:0] PRE_STEP_MA = 13'h0080;
	localparam logic [12:0] FAST_BASE_MA = 13'h0200;
	localparam logic [12:0] FAST_STEP_MA = 13'h0040;
	localparam logic [12:0] VREG_BASE_MV = 13'h0DB0;
	localparam logic [12:0] VREG_STEP_MV = 13'h0010;
	localparam logic [12:0] VCLAMP_STEP_MV = 13'h0010;
	localparam logic [12:0] WARM_HIGH_MV = 13'h1068;
	localparam logic [12:0] WARM_LOW_MV = 13'h0FD2;
	localparam logic [15:0] RCOMP_DIV = 16'h0064;

	typedef enum logic [1:0] {
		ST_OFF = 2'h0,
		ST_PRE = 2'h1,
		ST_FAST = 2'h3,
		ST_DONE = 2'h2
	} ccc_state_t;
endpackage

// File: core/ccc_sync3.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// three-stage input synchroniser with agreement filter
module ccc_sync3 #(
	parameter int unsigned W = 1
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			o_sync <= '0;
		end else begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					o_sync[i] <= s3[i];
				end
			end
		end
	end
endmodule // ccc_sync3
`default_nettype wire

// File: core/ccc_charge_ctrl.sv
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Summary of operation
// - input over current or under voltage lowers charge current until clear
// - overload at zero current with system below battery turns switch on
// - power-management status flag high while either limit loop acts
// - battery switch turns off when battery falls below depletion level
// - charge field resets to the enabled code 01
// - defaults 4.208 V, 2.048 A, 256 mA pre and term, 8 h timer
// - cycle starts only with converter on, enabled, no faults, switch free
// - cycle ends when current below term and battery above recharge
// - full battery dropping below recharge level starts a new cycle
// - status pin low charging, high done or off, blinking on timer fault or on thermistor fault while charging
// - phase code 00 off, 01 precharge, 10 fast, 11 done
// - interrupt raised each time a charge cycle completes
// - below 2 V 100 mA, 2-3 V precharge field, above 3 V fast field
// - while limiting, termination held off and timer runs half rate
// - regulation raised by min of current times resistance and clamp
// - charging only with thermistor inside T1 to T5, else suspended
// - warm zone regulates to 4.2 V or 4.05 V by a config bit
// - cool zone may cut current to 20 percent of fast setting
// - each interrupt is one pulse of 256 us
module ccc_charge_ctrl import ccc_pkg::*; #(
	parameter int unsigned P_INT_PULSE_CYC = INT_PULSE_CYC,
	parameter int unsigned P_BLINK_HALF_CYC = BLINK_HALF_CYC,
	parameter int unsigned P_TICK_CYC = TIMER_TICK_CYC
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_s_axi_awvalid,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_bready,
	input wire logic i_s_axi_arvalid,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_rready,
	output logic o_s_axi_awready,
	output logic o_s_axi_wready,
	output logic o_s_axi_bvalid,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_arready,
	output logic o_s_axi_rvalid,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	input wire logic i_in_over_current,
	input wire logic i_in_under_voltage,
	input wire logic i_thermal_reg,
	input wire logic i_sys_below_bat,
	input wire logic i_ichg_zero,
	input wire logic i_bat_deplete,
	input wire logic i_converter_on,
	input wire logic i_charge_enable_n,
	input wire logic i_bat_below_2v,
	input wire logic i_bat_below_3v,
	input wire logic i_bat_above_recharge,
	input wire logic i_ichg_below_term,
	input wire logic i_ts_cold,
	input wire logic i_ts_cool,
	input wire logic i_ts_warm,
	input wire logic i_ts_hot,
	input wire logic [12:0] i_ichg_actual_ma,
	output logic o_reduce_current,
	output logic o_battery_switch_on,
	output logic o_charge_en,
	output logic [12:0] o_ichg_ma,
	output logic [12:0] o_vreg_mv,
	output logic [7:0] o_input_limit,
	output logic o_recharge_sel,
	output logic o_stat_o,
	output logic o_stat_oe,
	output logic o_int
);
	// ==========================================================
	// input synchronisation
	logic [15:0] sy;
	ccc_sync3 #(.W(16)) u_sync (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_async({i_in_over_current, i_in_under_voltage, i_thermal_reg,
			i_sys_below_bat, i_ichg_zero, i_bat_deplete, i_converter_on,
			i_charge_enable_n, i_bat_below_2v, i_bat_below_3v,
			i_bat_above_recharge, i_ichg_below_term, i_ts_cold, i_ts_cool,
			i_ts_warm, i_ts_hot}),
		.o_sync(sy)
	);
	logic over_i, under_v, therm, sys_low, izero, deplete, conv_on;
	logic ce_n, below2, below3, above_rech, below_term;
	logic ts_cold, ts_cool, ts_warm, ts_hot;
	assign {over_i, under_v, therm, sys_low, izero, deplete, conv_on, ce_n,
		below2, below3, above_rech, below_term, ts_cold, ts_cool, ts_warm,
		ts_hot} = sy;

	// ==========================================================
	// register file
	logic [7:0] regs [0:7];
	logic [1:0] phase;
	logic pm_flag, therm_flag, timer_fault, ts_fault_q;

	function automatic logic [4:0] decode(input logic [7:0] a);
		// bit 4 flags a mapped word, low bits give the index
		if (a[1:0] == 2'h0 && a[7:2] <= OFS_FAULT_STATUS[7:2]) begin
			decode = {1'b1, a[5:2]};
		end else begin
			decode = 5'h00;
		end
	endfunction

	function automatic logic [7:0] reg_reset(input int idx);
		case (idx)
			0: reg_reset = RST_INPUT_LIMIT;
			1: reg_reset = RST_CHARGE_CONFIG;
			2: reg_reset = RST_FAST_CURRENT;
			3: reg_reset = RST_PRECHARGE_CURRENT;
			4: reg_reset = RST_VOLTAGE_CONFIG;
			5: reg_reset = RST_TIMER_TERM;
			6: reg_reset = RST_COMPENSATION;
			default: reg_reset = RST_MISC_CONTROL;
		endcase
	endfunction

	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [7:0] w_data;
	logic w_lane0;
	logic [4:0] wdec, rdec;
	logic do_write;
	assign wdec = decode(aw_addr);
	assign rdec = decode(i_s_axi_araddr);
	assign do_write = aw_held && w_held && !o_s_axi_bvalid;

	// write address and data are taken in either order
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
		end else begin
			o_s_axi_awready <= i_s_axi_awvalid && !o_s_axi_awready &&
				!aw_held;
			o_s_axi_wready <= i_s_axi_wvalid && !o_s_axi_wready && !w_held;
			if (o_s_axi_awready && i_s_axi_awvalid) begin
				aw_held <= 1'b1;
				aw_addr <= i_s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (o_s_axi_wready && i_s_axi_wvalid) begin
				w_held <= 1'b1;
				w_data <= i_s_axi_wdata[7:0];
				w_lane0 <= i_s_axi_wstrb[0];
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < 8; i++) begin
				regs[i] <= reg_reset(i);
			end
		end else if (do_write && wdec[4] && w_lane0 &&
			wdec[3:0] < NUM_RW_REGS) begin
			regs[wdec[2:0]] <= w_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			o_s_axi_bvalid <= 1'b1;
			o_s_axi_bresp <= wdec[4] ? RESP_OKAY : RESP_SLVERR;
		end else if (i_s_axi_bready) begin
			o_s_axi_bvalid <= 1'b0;
		end
	end

	// status words are read-only; writes to them are dropped silently
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
			o_s_axi_rresp <= RESP_OKAY;
		end else begin
			o_s_axi_arready <= i_s_axi_arvalid && !o_s_axi_arready &&
				!o_s_axi_rvalid;
			if (o_s_axi_arready && i_s_axi_arvalid) begin
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rresp <= rdec[4] ? RESP_OKAY : RESP_SLVERR;
				if (!rdec[4]) begin
					o_s_axi_rdata <= 32'h0000_0000;
				end else if (rdec[3:0] < NUM_RW_REGS) begin
					o_s_axi_rdata <= {24'h000000, regs[rdec[2:0]]};
				end else if (rdec[0]) begin
					o_s_axi_rdata <= {26'h0, timer_fault, ts_fault_q, 4'h0};
				end else begin
					o_s_axi_rdata <= {26'h0, phase, pm_flag, 1'b0,
						therm_flag, 1'b0};
				end
			end else if (i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// charge cycle sequencing
	logic input_power_limiting, slow, ts_fault, enable_ok, can_start, charging, term_cond;
	logic timer_en, half_en, expire;
	logic [16:0] timer_sec, timer_limit;
	ccc_state_t st, next_st;

	assign input_power_limiting = over_i || under_v;
	assign slow = input_power_limiting || therm;
	assign ts_fault = ts_cold || ts_hot;
	assign timer_en = regs[5][TT_TIMER_EN_BIT];
	assign half_en = regs[7][MISC_HALF_EN_BIT];
	assign enable_ok = conv_on && !ce_n && !regs[7][MISC_FORCE_OFF_BIT] &&
		regs[1][CFG_CHG_LSB +: 2] == CFG_CHG_ENABLE;
	assign can_start = enable_ok && !ts_fault && !timer_fault;
	assign charging = st == ST_PRE || st == ST_FAST;
	assign term_cond = regs[5][TT_TERM_EN_BIT] && below_term &&
		above_rech && !slow && !ts_fault;
	assign expire = timer_en && timer_sec >= timer_limit;

	always_comb begin
		case (regs[5][TT_TIMER_LSB +: 2])
			2'h0: timer_limit = 17'(5 * HOUR_SEC);
			2'h1: timer_limit = 17'(8 * HOUR_SEC);
			2'h2: timer_limit = 17'(12 * HOUR_SEC);
			default: timer_limit = 17'(20 * HOUR_SEC);
		endcase
	end

	always_comb begin
		next_st = st;
		case (st)
			ST_OFF: begin
				if (can_start) begin
					next_st = below3 ? ST_PRE : ST_FAST;
				end
			end
			ST_PRE, ST_FAST: begin
				if (!enable_ok || expire) begin
					next_st = ST_OFF;
				end else if (term_cond) begin
					next_st = ST_DONE;
				end else if (st == ST_PRE && !below3) begin
					next_st = ST_FAST;
				end
			end
			ST_DONE: begin
				if (!enable_ok) begin
					next_st = ST_OFF;
				end else if (!above_rech && can_start) begin
					next_st = below3 ? ST_PRE : ST_FAST;
				end
			end
			default: next_st = ST_OFF;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st <= ST_OFF;
		end else begin
			st <= next_st;
		end
	end

	// seconds prescaler; under limiting every other tick is skipped
	logic [31:0] tick_cnt;
	logic half_phase;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tick_cnt <= 32'h0000_0000;
			half_phase <= 1'b0;
			timer_sec <= 17'h00000;
			timer_fault <= 1'b0;
		end else begin
			tick_cnt <= (tick_cnt >= P_TICK_CYC - 1) ? 32'h0 : tick_cnt + 1;
			if (!charging) begin
				timer_sec <= 17'h00000;
			end else if (tick_cnt == 0 && timer_en && !ts_fault) begin
				half_phase <= !half_phase;
				if (!(slow && half_en) || half_phase) begin
					timer_sec <= timer_sec + 17'h00001;
				end
			end
			if (charging && expire) begin
				timer_fault <= 1'b1;
			end else if (!enable_ok) begin
				timer_fault <= 1'b0;
			end
		end
	end

	// ==========================================================
	// current and voltage targets
	logic [12:0] fast_ma, next_ichg, next_vreg, comp_mv, clamp_mv;
	logic [15:0] ir_prod;
	assign fast_ma = FAST_BASE_MA + 13'(regs[2][7:2]) * FAST_STEP_MA;
	assign ir_prod = 16'(i_ichg_actual_ma) * 16'(regs[6][7:5]);
	assign clamp_mv = 13'(regs[6][4:2]) * VCLAMP_STEP_MV;

	function automatic logic [12:0] min13(input logic [12:0] a,
		input logic [12:0] b);
		min13 = (a < b) ? a : b;
	endfunction

	always_comb begin
		comp_mv = min13(13'(ir_prod / RCOMP_DIV), clamp_mv);
		if (!charging || ts_fault) begin
			next_ichg = 13'h0000;
		end else if (below2) begin
			next_ichg = PRECOND_MA;
		end else if (st == ST_PRE) begin
			next_ichg = PRE_BASE_MA + 13'(regs[3][7:4]) * PRE_STEP_MA;
		end else if (ts_cool) begin
			next_ichg = regs[5][TT_COOL20_BIT] ? 13'(fast_ma / 5) :
				(fast_ma >> 1);
		end else begin
			next_ichg = fast_ma;
		end
		if (ts_warm) begin
			next_vreg = regs[7][MISC_WARM_LOW_BIT] ? WARM_LOW_MV :
				WARM_HIGH_MV;
		end else begin
			next_vreg = VREG_BASE_MV + 13'(regs[4][7:2]) * VREG_STEP_MV +
				comp_mv;
		end
	end

	// ==========================================================
	// power path, status and pin outputs
	logic supplement, done_evt, blink;
	logic [31:0] blink_cnt, int_cnt;
	assign done_evt = st != ST_DONE && next_st == ST_DONE;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			supplement <= 1'b0;
			o_battery_switch_on <= 1'b0;
			o_reduce_current <= 1'b0;
			pm_flag <= 1'b0;
			therm_flag <= 1'b0;
			ts_fault_q <= 1'b0;
			o_charge_en <= 1'b0;
			o_ichg_ma <= 13'h0000;
			o_vreg_mv <= 13'h0000;
			phase <= PH_DISABLED;
		end else begin
			if (deplete || regs[7][MISC_FORCE_OFF_BIT]) begin
				supplement <= 1'b0;
			end else if (input_power_limiting && izero && sys_low) begin
				supplement <= 1'b1;
			end
			o_battery_switch_on <= !deplete && !regs[7][MISC_FORCE_OFF_BIT] &&
				(charging || supplement || (input_power_limiting && izero && sys_low));
			o_reduce_current <= input_power_limiting;
			pm_flag <= input_power_limiting;
			therm_flag <= therm;
			ts_fault_q <= ts_fault;
			o_charge_en <= charging && !ts_fault;
			o_ichg_ma <= next_ichg;
			o_vreg_mv <= next_vreg;
			case (st)
				ST_PRE: phase <= PH_PRECHARGE;
				ST_FAST: phase <= PH_FAST;
				ST_DONE: phase <= PH_DONE;
				default: phase <= PH_DISABLED;
			endcase
		end
	end

	// open-drain status pin: enable pulls low
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			blink_cnt <= 32'h0000_0000;
			blink <= 1'b0;
			o_stat_o <= 1'b0;
			o_stat_oe <= 1'b0;
		end else begin
			o_stat_o <= 1'b0;
			if (blink_cnt >= P_BLINK_HALF_CYC - 1) begin
				blink_cnt <= 32'h0000_0000;
				blink <= !blink;
			end else begin
				blink_cnt <= blink_cnt + 32'h0000_0001;
			end
			if (timer_fault || (charging && ts_fault)) begin
				o_stat_oe <= blink;
			end else begin
				o_stat_oe <= charging;
			end
		end
	end

	// a new event restarts the pulse rather than stretching a queue
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			int_cnt <= 32'h0000_0000;
			o_int <= 1'b0;
		end else if (done_evt) begin
			int_cnt <= P_INT_PULSE_CYC;
			o_int <= 1'b1;
		end else if (int_cnt > 1) begin
			int_cnt <= int_cnt - 32'h0000_0001;
		end else begin
			int_cnt <= 32'h0000_0000;
			o_int <= 1'b0;
		end
	end

	assign o_input_limit = regs[0];
	assign o_recharge_sel = regs[4][VC_RECHARGE_BIT];

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	logic [31:0] int_len;
	logic [12:0] vreg_cap;
	// highest target that compensation may reach
	assign vreg_cap = VREG_BASE_MV + 13'(regs[4][7:2]) * VREG_STEP_MV +
		clamp_mv;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			int_len <= 32'h0000_0000;
		end else if (done_evt) begin
			int_len <= 32'h0000_0000; // a restarted pulse counts anew
		end else begin
			int_len <= o_int ? int_len + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	sequence s_enter_done;
		st != ST_DONE ##1 st == ST_DONE;
	endsequence
	sequence s_leave_off;
		st == ST_OFF ##1 st != ST_OFF;
	endsequence

	a_reduce_on_overload: assert property (input_power_limiting |=> o_reduce_current)
		else $error("overload did not reduce charge current");
	a_supplement_entry: assert property (input_power_limiting && izero && sys_low && !deplete
		&& !regs[7][MISC_FORCE_OFF_BIT] |=> o_battery_switch_on)
		else $error("supplement mode not entered");
	a_pm_flag_track: assert property (input_power_limiting ##1 input_power_limiting |-> pm_flag)
		else $error("power management flag low while limiting");
	a_deplete_off: assert property (deplete |=> !o_battery_switch_on)
		else $error("battery switch on below depletion");
	a_reset_defaults: assert property (!$past(i_resetn) |->
		regs[1] == RST_CHARGE_CONFIG && regs[2] == RST_FAST_CURRENT)
		else $error("wrong reset defaults");
	a_start_gate: assert property (s_leave_off |-> $past(can_start))
		else $error("cycle started without start conditions");
	a_term_done: assert property (charging && enable_ok && !expire
		&& term_cond |=> st == ST_DONE)
		else $error("termination missed");
	a_recharge_start: assert property (st == ST_DONE && enable_ok
		&& !above_rech && can_start |=> charging)
		else $error("recharge did not start");
	a_stat_charging: assert property (charging && !ts_fault && !timer_fault
		|=> o_stat_oe)
		else $error("status pin not low while charging");
	a_phase_fast: assert property (st == ST_FAST |=> phase == PH_FAST)
		else $error("wrong phase code in fast charge");
	a_done_int: assert property (s_enter_done |-> o_int)
		else $error("no interrupt on completion");
	a_precond_current: assert property (charging && !ts_fault && below2
		|=> o_ichg_ma == PRECOND_MA)
		else $error("precondition current wrong");
	a_no_term_slow: assert property (charging && slow |=> st != ST_DONE)
		else $error("terminated while limiting");
	a_comp_bounded: assert property (!ts_warm |=> o_vreg_mv <=
		$past(vreg_cap))
		else $error("compensation above clamp");
	a_ts_suspend: assert property (ts_fault |=> !o_charge_en)
		else $error("charging outside thermistor window");
	a_warm_voltage: assert property (ts_warm |=> o_vreg_mv == WARM_HIGH_MV
		|| o_vreg_mv == WARM_LOW_MV)
		else $error("warm zone voltage wrong");
	a_cool_current: assert property (st == ST_FAST && ts_cool && !ts_fault
		&& !below2 |=> o_ichg_ma == ($past(regs[5][TT_COOL20_BIT]) ?
		13'($past(fast_ma) / 5) : ($past(fast_ma) >> 1)))
		else $error("cool zone current wrong");
	a_int_width: assert property ($fell(o_int) |->
		int_len == P_INT_PULSE_CYC)
		else $error("interrupt pulse width wrong");
endmodule // ccc_charge_ctrl
`default_nettype wire

// File: bench/ccc_batt_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// battery voltage comparators on the far side
module ccc_batt_model #(
	parameter int unsigned RECHG_MV = 4108
) (
	input wire logic [12:0] i_bat_mv,
	output logic o_below_2v,
	output logic o_below_3v,
	output logic o_above_recharge
);
	// recharge level sits 100 mV under the default target
	assign o_below_2v = i_bat_mv < 13'h07D0;
	assign o_below_3v = i_bat_mv < 13'h0BB8;
	assign o_above_recharge = 32'(i_bat_mv) > RECHG_MV;
endmodule // ccc_batt_model
`default_nettype wire

// File: bench/charge_cycle_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// bench
module charge_cycle_controller_tb;
	logic clk, rstn, awv, wv, bry, arv, rry;
	logic [7:0] awa, ara;
	logic [31:0] wd, d;
	logic [12:0] bat;
	logic [15:0] cm;
	logic [1:0] r;
	wire logic awr, wrr, bv, arr, rv, b2, b3, arc, red, bsw, cen, soe, irq;
	wire logic so, rsel;
	wire logic [1:0] rresp, bresp;
	wire logic [7:0] ilim;
	wire logic [31:0] rdat;
	wire logic [12:0] ichg, vreg;
	int n_mismatch, check_count, i, n;
	logic [7:0] rst_v[8] = '{8'h00, 8'h10, 8'h60, 8'h11, 8'hB2, 8'h8A,
		8'h00, 8'h40};
	logic [12:0] row_bat[3] = '{13'h05DC, 13'h09C4, 13'h0DAC};
	logic [12:0] row_i[3] = '{13'h0064, 13'h0100, 13'h0800};
	logic [1:0] row_ph[3] = '{2'h1, 2'h1, 2'h2};

	ccc_batt_model bm_u (.i_bat_mv(bat), .o_below_2v(b2),
		.o_below_3v(b3), .o_above_recharge(arc));
	ccc_charge_ctrl #(.P_INT_PULSE_CYC(8), .P_BLINK_HALF_CYC(4),
		.P_TICK_CYC(2)) dut_u (.i_clk(clk), .i_resetn(rstn),
		.i_s_axi_awvalid(awv), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv),
		.i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_bready(bry),
		.i_s_axi_arvalid(arv), .i_s_axi_araddr(ara), .i_s_axi_rready(rry),
		.o_s_axi_awready(awr), .o_s_axi_wready(wrr), .o_s_axi_bvalid(bv),
		.o_s_axi_bresp(bresp), .o_s_axi_arready(arr),
		.o_s_axi_rvalid(rv),
		.o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp),
		.i_in_over_current(cm[0]), .i_in_under_voltage(cm[1]),
		.i_thermal_reg(cm[2]), .i_sys_below_bat(cm[3]),
		.i_ichg_zero(cm[4]), .i_bat_deplete(cm[5]),
		.i_converter_on(cm[6]), .i_charge_enable_n(cm[7]),
		.i_bat_below_2v(b2), .i_bat_below_3v(b3),
		.i_bat_above_recharge(arc), .i_ichg_below_term(cm[8]),
		.i_ts_cold(cm[9]), .i_ts_cool(cm[10]), .i_ts_warm(cm[11]),
		.i_ts_hot(cm[12]), .i_ichg_actual_ma(ichg),
		.o_reduce_current(red), .o_battery_switch_on(bsw),
		.o_charge_en(cen), .o_ichg_ma(ichg), .o_vreg_mv(vreg),
		.o_input_limit(ilim), .o_recharge_sel(rsel), .o_stat_o(so),
		.o_stat_oe(soe), .o_int(irq));

	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask

	// host side waits on each ready, never a fixed count
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		do begin
			@(posedge clk);
			if (awr) awv <= 0;
			if (wrr) wv <= 0;
		end while (!bv);
		r = bresp;
		bry <= 0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk);
		ara <= a; arv <= 1; rry <= 1;
		do begin
			@(posedge clk);
			if (arr) arv <= 0;
		end while (!rv);
		d = rdat;
		r = rresp;
		rry <= 0;
	endtask

	// comparators pass a three-stage filter first
	task st;
		repeat (10) @(posedge clk);
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		rstn = 0;
		awv = 0;
		wv = 0;
		bry = 0;
		arv = 0;
		rry = 0;
		awa = 0;
		ara = 0;
		wd = 0;
		bat = 13'h05DC;
		cm = 16'h0080;
		repeat (6) @(posedge clk);
		rstn <= 1;
		for (i = 0; i < 8; i++) begin
			rd(8'(4 * i));
			chk("reg", d, {24'h0, rst_v[i]});
		end
		rd(8'h30);
		chk("resp", r, 2'h2);
		chk("ilim", ilim, 8'h00);
		chk("rsel", rsel, 0);
		$display("reset test done");
		cm[6] <= 1;
		cm[7] <= 0;
		for (i = 0; i < 3; i++) begin
			bat <= row_bat[i];
			st;
			rd(8'h20);
			chk("ichg", ichg, row_i[i]);
			chk("phase", d[5:4], row_ph[i]);
			chk("en", cen, 1);
			chk("stat", soe, 1);
		end
		chk("vreg", vreg, 13'h1070);
		$display("row test done");
		cm[10] <= 1;
		st;
		chk("cool", ichg, 13'h0400);
		cm[10] <= 0;
		cm[0] <= 1;
		st;
		rd(8'h20);
		chk("lim", red, 1);
		chk("flag", d[3], 1);
		cm[0] <= 0;
		cm[12] <= 1;
		st;
		chk("hot", cen, 0);
		n = 0;
		repeat (16) begin
			@(posedge clk);
			if (soe) n++;
		end
		chk("blink", n, 8);
		chk("stat_o", so, 0);
		cm[12] <= 0;
		st;
		chk("back", cen, 1);
		bat <= 13'h1068;
		cm[8] <= 1;
		n = 0;
		repeat (40) begin
			@(posedge clk);
			if (irq) n++;
		end
		chk("int", n, 8);
		rd(8'h20);
		chk("done", d[5:4], 2'h3);
		chk("stat", soe, 0);
		chk("sw idle", bsw, 0);
		cm[0] <= 1;
		cm[3] <= 1;
		cm[4] <= 1;
		st;
		chk("suppl", bsw, 1);
		cm[5] <= 1;
		st;
		chk("deplete", bsw, 0);
		cm[0] <= 0;
		cm[5:3] <= 3'h0;
		cm[8] <= 0;
		bat <= 13'h0FA0;
		st;
		rd(8'h20);
		chk("again", d[5:4], 2'h2);
		wr(8'h08, 32'h0);
		chk("bresp", r, 2'h0);
		st;
		chk("fast", ichg, 13'h0200);
		wr(8'h18, 32'hFC);
		st;
		chk("comp", vreg, 13'h1093);
		wr(8'h18, 32'hE4);
		st;
		chk("clamp", vreg, 13'h1080);
		cm[11] <= 1;
		st;
		chk("warm", vreg, 13'h1068);
		wr(8'h1C, 32'h50);
		st;
		chk("warm low", vreg, 13'h0FD2);
		cm[11] <= 0;
		wr(8'h14, 32'h8B);
		cm[10] <= 1;
		st;
		chk("cool20", ichg, 13'h0066);
		cm[10] <= 0;
		$display("cycle test done");
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		rd(8'h08);
		chk("rst fast", d, 32'h60);
		rd(8'h14);
		chk("rst timer", d, 32'h8A);
		$display("mid-run reset test done");
		tally_and_finish;
	end
endmodule // charge_cycle_controller_tb
`default_nettype wire
